// file: sacc_top.sv
`default_nettype none
module sacc_top (
    input wire logic CLK,
    input wire logic RST_N,
    input wire sacc_pkg::sacc_cfg_t CFG,
    input wire logic START_WR1,
    input wire logic START_WR0,
    input wire logic DONE_WR0,
    input wire logic COMP_IN,
    output sacc_pkg::sacc_stat_t STAT,
    output sacc_pkg::sacc_analog_t ANA
);
    import sacc_pkg::*;

    // ***********************************************
    // State
    // ***********************************************
    typedef struct packed {
        sacc_state_t fsm;
        logic [5:0] cyc;
        logic [3:0] bit_idx;
        logic [11:0] sar;
        sacc_stat_t stat;
        sacc_analog_t ana;
    } sacc_st_t;

    sacc_st_t st_q, st_d;
    logic tick;
    logic [11:0] trial;
    logic [15:0] onehot;
    logic finish;

    sacc_clkdiv u_div (
        .CLK(CLK),
        .RST_N(RST_N),
        .div_sel(CFG.clk_div_sel),
        .tick(tick)
    );

    // Reserved code selects nothing rather than a random pin
    always_comb begin
        onehot = 16'h0000;
        if (CFG.channel_sel != CH_RESERVED) begin
            onehot[CFG.channel_sel] = 1'b1; // R8 R9 R16
        end
    end

    assign trial = st_q.sar | (12'h001 << st_q.bit_idx);
    assign finish = tick && st_q.fsm == SACC_CONVERT && st_q.cyc == LAST_CYCLE;

    // ***********************************************
    // Sequencer
    // ***********************************************
    always_comb begin
        st_d = st_q;
        st_d.ana.mux_onehot = onehot;
        st_d.ana.ref_use_bandgap = (CFG.ref_sel == REF_BANDGAP); // R6
        // Auto enable follows the channel; force keeps it up regardless
        st_d.ana.bandgap_enable = (CFG.channel_sel == CH_BANDGAP) // R10
            || CFG.bandgap_force_on; // R11
        if (DONE_WR0) begin
            st_d.stat.conversion_done_flag = 1'b0; // R4
        end
        case (st_q.fsm)
            SACC_IDLE: begin
                if (START_WR1) begin
                    st_d.stat.conversion_start = 1'b1; // R2
                    st_d.stat.conversion_done_flag = 1'b0; // R4
                    st_d.stat.busy = 1'b1;
                    st_d.fsm = SACC_SAMPLE;
                    st_d.cyc = 6'h00;
                    st_d.sar = 12'h000;
                    st_d.bit_idx = 4'(RES_BITS - 1);
                    st_d.ana.sample = 1'b1;
                end
            end
            SACC_SAMPLE: begin
                if (tick) begin
                    st_d.cyc = st_q.cyc + 6'h01; // R13
                    if (st_q.cyc == SAMPLE_CYCLES - 6'h01) begin
                        st_d.fsm = SACC_CONVERT;
                        st_d.ana.sample = 1'b0;
                        st_d.ana.dac_code = trial;
                    end
                end
            end
            SACC_CONVERT: begin
                if (tick) begin
                    st_d.cyc = st_q.cyc + 6'h01; // R13
                    // Odd cycle of each bit pair decides; even one lets the DAC settle
                    if (st_q.cyc[0] != SAMPLE_CYCLES[0]) begin
                        st_d.sar = COMP_IN ? trial : st_q.sar; // R5
                        if (st_q.bit_idx != 4'h0) begin
                            st_d.bit_idx = st_q.bit_idx - 4'h1;
                            st_d.ana.dac_code = (COMP_IN ? trial : st_q.sar)
                                | (12'h001 << (st_q.bit_idx - 4'h1));
                        end
                    end
                    if (finish) begin
                        st_d.fsm = SACC_IDLE;
                        st_d.stat.busy = 1'b0;
                        st_d.stat.conversion_start = 1'b0; // R2
                        st_d.stat.conversion_done_flag = 1'b1; // R3
                        st_d.stat.result_high_byte = st_d.sar[11:4]; // R15 R17
                        st_d.stat.result_low_byte = {st_d.sar[3:0], 4'h0}; // R15
                    end
                end
            end
            default: st_d.fsm = SACC_IDLE;
        endcase
        // Software abort: no result, results kept
        if (START_WR0 && !START_WR1 && st_q.fsm != SACC_IDLE && !finish) begin
            st_d.fsm = SACC_IDLE;
            st_d.stat.busy = 1'b0;
            st_d.stat.conversion_start = 1'b0;
            st_d.ana.sample = 1'b0;
        end
        st_d.stat.irq = st_d.stat.conversion_done_flag && CFG.irq_enable; // R3
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= '0;
            st_q.ana.mux_onehot <= 16'h0001 << CHSEL_RESET;
            st_q.ana.bandgap_enable <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign STAT = st_q.stat;
    assign ANA = st_q.ana;

    // ***********************************************
    // Checks
    // ***********************************************
    int unsigned ticks_q;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ticks_q <= 0;
        end else if (st_q.fsm == SACC_IDLE) begin
            ticks_q <= 0;
        end else if (tick) begin
            ticks_q <= ticks_q + 1;
        end
    end

    conv_length_a: assert property (@(posedge CLK) disable iff (!RST_N) // R13
        $fell(st_q.stat.busy) && st_q.stat.conversion_done_flag
        |-> $past(ticks_q) == CONV_CYCLES - 1)
        else $error("conversion length is not 50 converter clocks");
    start_clear_a: assert property (@(posedge CLK) disable iff (!RST_N) // R2
        $rose(st_q.stat.conversion_done_flag) |-> !st_q.stat.conversion_start)
        else $error("start bit still set at end of conversion");
    start_launch_a: assert property (@(posedge CLK) disable iff (!RST_N) // R2
        (st_q.fsm == SACC_IDLE && START_WR1) |=> st_q.stat.conversion_start
        && st_q.fsm == SACC_SAMPLE)
        else $error("start write did not launch");
    done_clear_a: assert property (@(posedge CLK) disable iff (!RST_N) // R4
        (DONE_WR0 && !finish) |=> !st_q.stat.conversion_done_flag)
        else $error("done flag not cleared by write of 0");
    irq_gate_a: assert property (@(posedge CLK) disable iff (!RST_N) // R3
        ##1 st_q.stat.irq == (st_q.stat.conversion_done_flag && $past(CFG.irq_enable)))
        else $error("interrupt request not equal to flag and enable");
    result_hold_a: assert property (@(posedge CLK) disable iff (!RST_N) // R17
        !$past(finish) |-> $stable(st_q.stat.result_high_byte)
        && $stable(st_q.stat.result_low_byte))
        else $error("result changed outside conversion end");
    low_nibble_a: assert property (@(posedge CLK) disable iff (!RST_N) // R15
        st_q.stat.result_low_byte[3:0] == 4'h0)
        else $error("low byte low nibble not zero");
    // Skip the edge after reset: outputs still hold reset values there
    bg_enable_a: assert property (@(posedge CLK) disable iff (!RST_N) // R10 R11
        $past(RST_N) && ($past(CFG.bandgap_force_on) || $past(CFG.channel_sel) == CH_BANDGAP)
        |-> st_q.ana.bandgap_enable)
        else $error("bandgap generator not enabled");
    mux_pick_a: assert property (@(posedge CLK) disable iff (!RST_N) // R16
        ##1 ($past(CFG.channel_sel) == CH_QUARTER) |-> st_q.ana.mux_onehot == 16'h8000)
        else $error("quarter supply not selected");

    // ***********************************************
    // Control and routing checks
    // ***********************************************
    done_set_a: assert property (@(posedge CLK) disable iff (!RST_N) // R3
        finish |=> st_q.stat.conversion_done_flag)
        else $error("done flag not set at end of conversion");
    start_ignore_a: assert property (@(posedge CLK) disable iff (!RST_N) // R2
        (st_q.fsm != SACC_IDLE && START_WR1 && !finish) |=> st_q.stat.busy)
        else $error("start write while busy disturbed the conversion");
    start_busy_a: assert property (@(posedge CLK) disable iff (!RST_N) // R2
        st_q.stat.conversion_start == st_q.stat.busy)
        else $error("start bit and busy disagree");
    abort_stop_a: assert property (@(posedge CLK) disable iff (!RST_N) // R2
        (START_WR0 && !START_WR1 && st_q.stat.busy && !finish)
        |=> !st_q.stat.busy && !st_q.stat.conversion_done_flag)
        else $error("write of 0 did not stop the conversion");
    sample_phase_a: assert property (@(posedge CLK) disable iff (!RST_N) // R13
        st_q.ana.sample |-> st_q.fsm == SACC_SAMPLE)
        else $error("sampling outside the sample phase");
    bg_auto_off_a: assert property (@(posedge CLK) disable iff (!RST_N) // R10
        $past(RST_N) && !$past(CFG.bandgap_force_on) && $past(CFG.channel_sel) != CH_BANDGAP
        |-> !st_q.ana.bandgap_enable)
        else $error("bandgap generator left on");
    mux_exact_a: assert property (@(posedge CLK) disable iff (!RST_N) // R9
        $past(RST_N) && $past(CFG.channel_sel) != CH_RESERVED
        |-> st_q.ana.mux_onehot == (16'h0001 << $past(CFG.channel_sel)))
        else $error("multiplexer does not match channel code");
    ref_pick_a: assert property (@(posedge CLK) disable iff (!RST_N) // R6
        $past(RST_N) |-> st_q.ana.ref_use_bandgap == ($past(CFG.ref_sel) == REF_BANDGAP))
        else $error("reference choice does not match select");
    irq_off_a: assert property (@(posedge CLK) disable iff (!RST_N) // R3
        $past(RST_N) && !$past(CFG.irq_enable) |-> !st_q.stat.irq)
        else $error("interrupt request while disabled");

    // ***********************************************
    // Cover points
    // ***********************************************
    conv_done_c: cover property (@(posedge CLK) disable iff (!RST_N)
        $rose(st_q.stat.conversion_done_flag));
    irq_c: cover property (@(posedge CLK) disable iff (!RST_N) $rose(st_q.stat.irq));
    restart_c: cover property (@(posedge CLK) disable iff (!RST_N)
        st_q.stat.conversion_done_flag && START_WR1);
    abort_c: cover property (@(posedge CLK) disable iff (!RST_N)
        st_q.stat.busy && START_WR0);
    bg_force_c: cover property (@(posedge CLK) disable iff (!RST_N)
        st_q.ana.bandgap_enable && !st_q.ana.mux_onehot[CH_BANDGAP]);
endmodule : sacc_top
`default_nettype wire

// file: sacc_pkg.sv
// Notes on behaviour
// (R1) Software picks a divider that keeps the converter clock below 1 MHz.
// (R2) Writing 1 to conversion_start launches a conversion and hardware clears the bit at its end.
// (R3) At the end of a conversion the done flag is set and an interrupt request is raised if enabled.
// (R4) The done flag clears when software writes 0 to it or writes 1 to conversion_start.
// (R5) Each result is 12 bits, built bit by bit in a successive-approximation register.
// (R6) The reference select offers the supply and the scaled bandgap as usable references.
// (R7) With the bandgap channel selected, software must choose the supply reference.
// (R8) The input multiplexer offers 15 sources: inputs 0-9, 12-14, bandgap and quarter supply.
// (R9) The multiplexer connects exactly the source encoded in the channel select field.
// (R10) Selecting the bandgap channel enables the bandgap generator automatically.
// (R11) With bandgap_force_on set, the bandgap generator stays enabled on any channel.
// (R12) Software keeps the converter channel apart from any touch-sensing channel.
// (R13) One conversion takes 50 converter clock cycles, two per result bit plus sampling.
// (R14) Divider select 00/01/10/11 divides the system clock by 32/16/8/4.
// (R15) Result bits 11..4 go to the high byte and bits 3..0 to the top of the low byte.
// (R16) Channel code 1011 selects the bandgap and 1111 the quarter supply.
// (R17) The result registers hold the last result until the next conversion overwrites them.
`default_nettype none
package sacc_pkg;
    localparam int RES_BITS = 12;
    localparam int CONV_CYCLES = 50;
    localparam int BIT_CYCLES = 2;
    localparam logic [5:0] SAMPLE_CYCLES = 6'(CONV_CYCLES - RES_BITS * BIT_CYCLES);
    localparam logic [5:0] LAST_CYCLE = 6'(CONV_CYCLES - 1);
    localparam logic [3:0] CH_BANDGAP = 4'hB;
    localparam logic [3:0] CH_QUARTER = 4'hF;
    localparam logic [3:0] CH_RESERVED = 4'hA;
    localparam logic [1:0] REF_SUPPLY = 2'h0;
    localparam logic [1:0] REF_BANDGAP = 2'h1;
    localparam logic [3:0] CHSEL_RESET = 4'hF;
    localparam logic [4:0] DIV32_TOP = 5'h1F;
    localparam logic [4:0] DIV16_TOP = 5'h0F;
    localparam logic [4:0] DIV8_TOP = 5'h07;
    localparam logic [4:0] DIV4_TOP = 5'h03;

    typedef enum logic [1:0] {
        SACC_IDLE = 2'b00,
        SACC_SAMPLE = 2'b01,
        SACC_CONVERT = 2'b10
    } sacc_state_t;

    typedef struct packed {
        logic [1:0] clk_div_sel;
        logic [3:0] channel_sel;
        logic [1:0] ref_sel;
        logic bandgap_force_on;
        logic irq_enable;
    } sacc_cfg_t;

    typedef struct packed {
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
        logic conversion_start;
        logic conversion_done_flag;
        logic irq;
        logic busy;
    } sacc_stat_t;

    typedef struct packed {
        logic [15:0] mux_onehot;
        logic ref_use_bandgap;
        logic bandgap_enable;
        logic sample;
        logic [11:0] dac_code;
    } sacc_analog_t;
endpackage : sacc_pkg
`default_nettype wire

// file: sacc_clkdiv.sv
`default_nettype none
module sacc_clkdiv (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic [1:0] div_sel,
    output logic tick
);
    import sacc_pkg::*;

    typedef struct packed {
        logic [4:0] cnt;
        logic tick;
    } sacc_div_st_t;

    sacc_div_st_t st_q, st_d;
    logic [4:0] top;

    always_comb begin
        case (div_sel) // R14
            2'b00: top = DIV32_TOP;
            2'b01: top = DIV16_TOP;
            2'b10: top = DIV8_TOP;
            default: top = DIV4_TOP;
        endcase
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt >= top) begin
            st_d.cnt = 5'h00;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 5'h01;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;

    // ***********************************************
    // Divider spacing check
    // ***********************************************
    div4_period_a: assert property (@(posedge CLK) disable iff (!RST_N) // R14
        (st_q.tick && div_sel == 2'b11 && $stable(div_sel)) |=> !st_q.tick [*3])
        else $error("divide-by-4 tick came early");
endmodule : sacc_clkdiv
`default_nettype wire

// file: sacc_ana_model.sv
`default_nettype none
module sacc_ana_model (
    input wire logic clk,
    input wire sacc_pkg::sacc_analog_t ana,
    output logic comp
);
    timeunit 1ns;
    timeprecision 1ns;
    import sacc_pkg::*;
    // **********
    // Analog sources and comparator
    // **********
    logic [11:0] held = 12'h000;
    logic [11:0] sel_level;
    logic flip = 1'b0;
    always_comb begin
        sel_level = 12'h000;
        for (int i = 0; i < 16; i++) begin
            if (ana.mux_onehot[i]) begin
                // Pins are plain converter inputs, none shared with touch sensing
                sel_level = 12'h0A5 + 12'(i) * 12'h0F3;
            end
        end
    end
    // Holds the sampled level like a real hold capacitor
    always @(posedge clk) begin
        flip <= ~flip;
        if (ana.sample) begin
            held <= sel_level;
        end
    end
    // Nothing selected: toggles so no settled value can pass for a result
    assign comp = (|ana.mux_onehot) ? (held >= ana.dac_code) : flip;
endmodule : sacc_ana_model
`default_nettype wire

// file: sar_adc_conversion_control_tb_top.sv
`default_nettype none
module sar_adc_conversion_control_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import sacc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic s1 = 1'b0;
    logic s0 = 1'b0;
    logic d0 = 1'b0;
    logic comp;
    sacc_cfg_t cfg = '0;
    sacc_stat_t stat;
    sacc_analog_t ana;
    logic [15:0] last_res = 16'h0000;
    int miscompares = 0;
    int tests_run = 0;
    int cyc;
    always #20 clk = ~clk;
    sacc_top uut (.CLK(clk), .RST_N(rst_n), .CFG(cfg), .START_WR1(s1), .START_WR0(s0),
        .DONE_WR0(d0), .COMP_IN(comp), .STAT(stat), .ANA(ana));
    sacc_ana_model model (.clk(clk), .ana(ana), .comp(comp));
    // **********
    // Helpers
    // **********
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'b1;
        @(negedge clk);
        s = 1'b0;
    endtask : pulse
    task automatic convert(input logic [1:0] div, input logic [3:0] ch, input logic ie);
        logic [15:0] exp_res;
        int d;
        d = 32 >> div;
        exp_res = {12'h0A5 + 12'(ch) * 12'h0F3, 4'h0};
        @(negedge clk);
        cfg.clk_div_sel = div;
        cfg.channel_sel = ch;
        cfg.ref_sel = REF_SUPPLY;
        cfg.irq_enable = ie;
        pulse(s1);
        chk("start_busy_done", 20'hE, 20'({stat.conversion_start, stat.busy, ana.sample,
            stat.conversion_done_flag}));
        chk("held_result", 20'(last_res), 20'({stat.result_high_byte,
            stat.result_low_byte}));
        cyc = 1;
        while (stat.conversion_done_flag !== 1'b1 && cyc < 2000) begin
            @(negedge clk);
            cyc++;
        end
        chk("conv_cycles", 20'h1, 20'(cyc >= 49 * d && cyc <= 50 * d + 3));
        chk("result", 20'(exp_res), 20'({stat.result_high_byte, stat.result_low_byte}));
        chk("start_busy_irq", 20'(ie), 20'({stat.conversion_start, stat.busy, ana.sample,
            stat.irq}));
        last_res = exp_res;
    endtask : convert
    // **********
    // Scenarios
    // **********
    task automatic t_reset();
        chk("reset_stat", 20'h0, 20'(stat));
        chk("reset_mux", 20'h8000, 20'(ana.mux_onehot));
    endtask : t_reset
    task automatic t_conversions();
        convert(2'h0, 4'h3, 1'b1);
        pulse(d0);
        chk("flag_clear", 20'h0, 20'({stat.conversion_done_flag, stat.irq}));
        convert(2'h1, 4'hC, 1'b0);
        // Back-to-back: flag left set so the start must clear it
        convert(2'h2, 4'hB, 1'b1);
        convert(2'h3, 4'hF, 1'b1);
    endtask : t_conversions
    task automatic t_abort();
        @(negedge clk);
        cfg.clk_div_sel = 2'h0;
        cfg.channel_sel = 4'h5;
        cfg.ref_sel = REF_SUPPLY;
        cfg.irq_enable = 1'b1;
        pulse(s1);
        repeat (100) @(negedge clk);
        // Second start lands in the sample phase and must be ignored
        pulse(s1);
        chk("start_ignored", 20'hE, 20'({stat.conversion_start, stat.busy, ana.sample,
            stat.conversion_done_flag}));
        pulse(s0);
        chk("abort_stat", 20'h0, 20'({stat.conversion_start, stat.busy, ana.sample,
            stat.conversion_done_flag, stat.irq}));
        chk("abort_result", 20'(last_res), 20'({stat.result_high_byte,
            stat.result_low_byte}));
        convert(2'h0, 4'h5, 1'b0);
    endtask : t_abort
    task automatic t_mux();
        logic [3:0] ch;
        for (int i = 0; i < 16; i++) begin
            ch = 4'(i);
            @(negedge clk);
            cfg.channel_sel = ch;
            cfg.bandgap_force_on = 1'b0;
            cfg.ref_sel = (ch == CH_BANDGAP) ? REF_SUPPLY : REF_BANDGAP;
            repeat (2) @(negedge clk);
            chk("mux", (ch == CH_RESERVED) ? 20'h0 : 20'(16'h0001 << i), 20'(ana.mux_onehot));
            chk("bg_auto", 20'(ch == CH_BANDGAP), 20'(ana.bandgap_enable));
            chk("ref_bg", 20'(ch != CH_BANDGAP), 20'(ana.ref_use_bandgap));
        end
        cfg.channel_sel = 4'h3;
        cfg.bandgap_force_on = 1'b1;
        cfg.ref_sel = 2'h2;
        repeat (2) @(negedge clk);
        chk("bg_force_ref", 20'h2, 20'({ana.bandgap_enable, ana.ref_use_bandgap}));
    endtask : t_mux
    task automatic end_of_test();
        $display("Counts: tests_run=%0d miscompares=%0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        #(40 * 20000);
        miscompares++;
        end_of_test();
    end
    initial begin
        repeat (4) @(negedge clk);
        t_reset();
        rst_n = 1'b1;
        t_conversions();
        t_abort();
        t_mux();
        end_of_test();
    end
endmodule : sar_adc_conversion_control_tb_top
`default_nettype wire
